/* File: hdl/stc_map.svh */
// register map, field positions, reset values and timing constants of the stepper control block
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

`define STC_ADDR_NULL      5'h00
`define STC_ADDR_DRIVE     5'h01
`define STC_ADDR_PWMDET    5'h02
`define STC_ADDR_SPARE     5'h03
`define STC_ADDR_POSITION  5'h04
`define STC_ADDR_FAULT     5'h05
`define STC_ADDR_SHORT     5'h06

`define STC_DRIVE_RESET    9'h000
`define STC_PWMDET_RESET   9'h088
`define STC_POSITION_RESET 6'h08

`define STC_DRIVE_ADVANCE  8
`define STC_DRIVE_ENABLE   7
`define STC_DRIVE_INVERT   6
`define STC_PWMDET_DITHER  8

`define STC_SR_PARITY      8
`define STC_SR1_STEPLOSS   7
`define STC_SR1_LINKERR    6
`define STC_SR1_DEFECT     5
`define STC_SR1_AMBIENT    4
`define STC_SR1_THERMAL    3
`define STC_SR1_WARNING    2
`define STC_SR1_UNDERVOLT  1
`define STC_SR2_AUX        5
`define STC_SR2_OPEN_COIL_X_FLAG      4
`define STC_SR2_XPB        3
`define STC_SR2_XNB        2
`define STC_SR2_XPT        1
`define STC_SR2_XNT        0

`define STC_FRAME_BITS     16
`define STC_FRAME_WRITE    15

`define STC_CLK_HZ         20000000
`define STC_OSC_HZ         10000000
`define STC_OSC_DIV        (`STC_CLK_HZ / `STC_OSC_HZ)
`define STC_PWM_HZ         28400
`define STC_PWM_TICKS      (`STC_OSC_HZ / `STC_PWM_HZ)
`define STC_JIT_PCT        20
`define STC_JIT_MAX        ((`STC_PWM_TICKS * `STC_JIT_PCT) / 100)

`endif

/* File: hdl/stc_pkg.sv */
// types shared by the stepper control block
`default_nettype none
package stc_pkg;

  typedef struct packed {
    logic       write;
    logic [4:0] addr;
    logic [9:0] data;
  } stc_frame_type;

  // analog-side conditions, all asynchronous levels
  typedef struct packed {
    logic       undervolt;
    logic       thermal;
    logic       warning;
    logic       defect;
    logic       ambient;
    logic       aux;
    logic       open_coil_x_flag;
    logic [3:0] shortTop;   // {y neg, y pos, x neg, x pos}
    logic [1:0] shortBot;   // {x neg, x pos}
    logic [3:0] switchUp;   // pin is switching bottom to top
  } stc_sense_type;

  typedef struct packed {
    logic [3:0] coilCurrentLevel;
    logic       currentSurgeEnable;
    logic       activeBrake;
    logic [1:0] openCoilDetectTime;
    logic       openCoilDetectOff;
    logic       openCoilFloat;
    logic       sleepEnable;
    logic [2:0] stepModeSelect;
    logic       pwmDitherEnable;
  } stc_cfg_type;

endpackage : stc_pkg
`default_nettype wire

/* File: hdl/stc_spi_link.sv */
// serial link shifter running on the host's serial clock
`default_nettype none
module stc_spi_link
  import stc_pkg::*;
(
  input  wire logic        sck,
  input  wire logic        arstN,
  input  wire logic        chipSelectN,
  input  wire logic        serialIn,
  input  wire logic [15:0] txWord,
  output logic             serialOut,
  output stc_frame_type    rxFrame,
  output logic             rxToggle
);

  logic [3:0]  bitCnt;
  logic [15:0] rxShift;
  logic [15:0] txShift;

  // counter restarts whenever the chip is deselected, so a short frame is dropped
  always_ff @(posedge sck or posedge chipSelectN) begin
    if (chipSelectN) begin
      bitCnt  <= 4'h0;
      rxShift <= 16'h0000;
      txShift <= 16'h0000;
    end else begin
      bitCnt  <= bitCnt + 4'h1;
      rxShift <= {rxShift[14:0], serialIn};
      txShift <= (bitCnt == 4'h0) ? {txWord[14:0], 1'b0} : {txShift[14:0], 1'b0};
    end
  end

  // txWord is quasi-static: it only changes well before the next frame begins
  assign serialOut = (bitCnt == 4'h0) ? txWord[15] : txShift[15];

  // frame word held stable until the next complete frame; toggle marks it
  always_ff @(posedge sck or negedge arstN) begin
    if (!arstN) begin
      rxFrame  <= '0;
      rxToggle <= 1'b0;
    end else if (!chipSelectN && bitCnt == 4'hf) begin
      rxFrame  <= {rxShift[14:0], serialIn};
      rxToggle <= ~rxToggle;
    end
  end

endmodule : stc_spi_link
`default_nettype wire

/* File: hdl/stepper_translator_ctrl.sv */
// control logic of the stepper translator: register map, position, step loss and bridge enable
//
// Functional notes
// (RULE1) position is a 6-bit field, readable and writable over the serial link
// (RULE2) position counts sixteenths of a step, updated right after each trigger
// (RULE3) effective direction is direction pin xor invert bit
// (RULE4) positive direction moves the current vector counter-clockwise (angle increases)
// (RULE5) host rewrites bridge enable to one after reading faults
// (RULE6) host must not keep re-enabling bridges into a persistent short
// (RULE7) top short seen while switching bottom-to-top is reported as bottom short; code remaps shortTop[0], [1] only and drops [2], [3] while switching up
// (RULE8) step loss set by any step or position write during fault condition
// (RULE9) step loss clears when its status register is read
// (RULE10) address zero accesses are ignored entirely
// (RULE11) all control registers are readable and writable
// (RULE12) writing the advance bit steps exactly like the pin
// (RULE13) bridge enable bit powers the bridges when set
// (RULE14) status registers read-only with odd parity at bit eight
// (RULE15) sequencing timed from an internal 10 MHz tick
// (RULE16) dither spreads the pwm period by at most 20 percent
// (RULE17) each accepted step moves position by one, wrapping modulo 64
// (RULE18) unused control bits ignore writes and read zero
// (RULE19) latched flags hold until their status register is read
`default_nettype none
`include "stc_map.svh"
module stepper_translator_ctrl
  import stc_pkg::*;
#(
  parameter int POS_W = 6
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          arst_n,
  input  wire logic          linkClk,
  input  wire logic          chipSelectN,
  input  wire logic          serialIn,
  output logic               serialOut,
  input  wire logic          advanceStepPin,
  input  wire logic          directionPin,
  input  wire stc_sense_type sense,
  output logic               faultOutNO,
  output logic               faultOutNOe,
  output logic               bridgeOn,
  output logic [POS_W-1:0]   coilAngle,
  output logic               stepDirection,
  output logic               pwmSync,
  output stc_cfg_type        cfg
);

  typedef struct packed {
    logic [2:0]       frameSync;
    logic [1:0]       stepSync;
    logic             stepPrev;
    logic [1:0]       dirSync;
    stc_sense_type    senseS1;
    stc_sense_type    senseS2;
    logic [8:0]       drive;
    logic [8:0]       pwmDet;
    logic [POS_W-1:0] position;
    logic [7:0]       faultLat;
    logic [5:0]       shortLat;
    logic [9:0]       readWord;
    logic [1:0]       oscCnt;
    logic [9:0]       pwmCnt;
    logic [9:0]       pwmLen;
    logic [5:0]       lfsr;
    logic             pwmPulse;
    logic             dirOut;
  } stc_state_type;

  localparam logic [9:0] PwmTicks = 10'(`STC_PWM_TICKS);
  localparam logic [1:0] OscLast  = 2'(`STC_OSC_DIV - 1);

  stc_state_type q;
  stc_state_type d;
  logic [1:0]    rstSync;
  logic          rstN;
  stc_frame_type linkFrame;
  logic          linkToggle;
  stc_frame_type frame;
  logic          frameValid;
  logic          errActive;
  logic          effDir;
  logic          stepEdge;
  logic          advanceWrite;
  logic          posWrite;
  logic          stepTrig;
  logic          faultRead;
  logic          shortRead;
  logic          oscTick;
  logic [9:0]    faultWord;
  logic [9:0]    shortWord;
  logic [7:0]    faultSet;
  logic [5:0]    shortSet;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  stc_spi_link u_link (
    .sck         (linkClk),
    .arstN       (arst_n),
    .chipSelectN (chipSelectN),
    .serialIn    (serialIn),
    .txWord      ({6'h00, q.readWord}),
    .serialOut   (serialOut),
    .rxFrame     (linkFrame),
    .rxToggle    (linkToggle)
  );

  // frame word is held by the link until the next frame, so it is safe once the toggle is seen
  assign frame      = linkFrame;
  assign frameValid = ce && (q.frameSync[2] ^ q.frameSync[1]);
  assign faultRead  = frameValid && !frame.write && frame.addr == `STC_ADDR_FAULT;
  assign shortRead  = frameValid && !frame.write && frame.addr == `STC_ADDR_SHORT;

  assign errActive    = q.senseS2.undervolt | q.senseS2.thermal | q.senseS2.defect;
  assign effDir       = q.dirSync[1] ^ q.drive[`STC_DRIVE_INVERT]; // RULE3
  assign stepEdge     = ce && q.stepSync[1] && !q.stepPrev;
  assign advanceWrite = frameValid && frame.write && frame.addr == `STC_ADDR_DRIVE &&
                        frame.data[`STC_DRIVE_ADVANCE]; // RULE12
  assign posWrite     = frameValid && frame.write && frame.addr == `STC_ADDR_POSITION;
  assign stepTrig     = stepEdge || advanceWrite;
  assign oscTick      = ce && q.oscCnt == OscLast; // RULE15

  // set terms of the latched flags; real-time bits are only read live
  always_comb begin
    faultSet = 8'h00;
    shortSet = 6'h00;
    faultSet[`STC_SR1_STEPLOSS]  = errActive && (stepTrig || posWrite); // RULE8
    faultSet[`STC_SR1_LINKERR]   = frameValid && frame.write && frame.addr > `STC_ADDR_SPARE &&
                                   frame.addr != `STC_ADDR_POSITION;
    faultSet[`STC_SR1_THERMAL]   = q.senseS2.thermal;
    faultSet[`STC_SR1_UNDERVOLT] = q.senseS2.undervolt;
    shortSet[`STC_SR2_AUX]       = q.senseS2.aux;
    shortSet[`STC_SR2_OPEN_COIL_X_FLAG]     = q.senseS2.open_coil_x_flag;
    // a top short on shortTop[0] or [1] caught mid bottom-to-top transition shows as a bottom short
    shortSet[`STC_SR2_XPB] = q.senseS2.shortBot[0] |
                             (q.senseS2.shortTop[0] & q.senseS2.switchUp[0]); // RULE7
    shortSet[`STC_SR2_XNB] = q.senseS2.shortBot[1] |
                             (q.senseS2.shortTop[1] & q.senseS2.switchUp[1]); // RULE7
    shortSet[`STC_SR2_XPT] = (q.senseS2.shortTop[0] & ~q.senseS2.switchUp[0]) |
                             (q.senseS2.shortTop[2] & ~q.senseS2.switchUp[2]);
    shortSet[`STC_SR2_XNT] = (q.senseS2.shortTop[1] & ~q.senseS2.switchUp[1]) |
                             (q.senseS2.shortTop[3] & ~q.senseS2.switchUp[3]);
  end

  always_comb begin
    faultWord = 10'h000;
    faultWord[7:1] = q.faultLat[7:1];
    faultWord[`STC_SR1_DEFECT]  = q.senseS2.defect;
    faultWord[`STC_SR1_AMBIENT] = q.senseS2.ambient;
    faultWord[`STC_SR1_WARNING] = q.senseS2.warning;
    faultWord[`STC_SR_PARITY]   = ~^faultWord[7:0]; // RULE14
    shortWord = 10'h000;
    shortWord[5:0] = q.shortLat;
    shortWord[`STC_SR_PARITY]   = ~^shortWord[7:0]; // RULE14
  end

  always_comb begin
    d = q;
    if (ce) begin
      d.frameSync = {q.frameSync[1:0], linkToggle};
      d.stepSync  = {q.stepSync[0], advanceStepPin};
      d.stepPrev  = q.stepSync[1];
      d.dirSync   = {q.dirSync[0], directionPin};
      d.senseS1   = sense;
      d.senseS2   = q.senseS1;
      d.dirOut    = effDir;

      // read data shows state before this frame's side effects
      if (frameValid && !frame.write) begin
        if (frame.addr == `STC_ADDR_NULL) begin
          d.readWord = q.readWord; // RULE10
        end else if (frame.addr == `STC_ADDR_DRIVE) begin
          d.readWord = {1'b0, q.drive}; // RULE11 RULE18
        end else if (frame.addr == `STC_ADDR_PWMDET) begin
          d.readWord = {1'b0, q.pwmDet}; // RULE11
        end else if (frame.addr == `STC_ADDR_POSITION) begin
          d.readWord = {4'h0, q.position}; // RULE1
        end else if (frame.addr == `STC_ADDR_FAULT) begin
          d.readWord = faultWord;
        end else if (frame.addr == `STC_ADDR_SHORT) begin
          d.readWord = shortWord;
        end else begin
          d.readWord = 10'h000;
        end
      end

      if (frameValid && frame.write) begin
        if (frame.addr == `STC_ADDR_DRIVE) begin
          d.drive = frame.data[8:0]; // RULE11 RULE18
        end else if (frame.addr == `STC_ADDR_PWMDET) begin
          d.pwmDet = frame.data[8:0];
        end
      end

      // steps during a fault are lost: position holds and the loss is flagged
      if (posWrite) begin
        d.position = frame.data[POS_W-1:0]; // RULE1
      end else if (stepTrig && !errActive) begin
        d.position = effDir ? POS_W'(q.position + 1'b1)   // RULE2 RULE4 RULE17
                            : POS_W'(q.position - 1'b1);  // RULE17
      end

      // set wins over the clear of a read in the same cycle
      d.faultLat = (q.faultLat & ~(faultRead ? 8'hff : 8'h00)) | faultSet; // RULE9 RULE19
      d.shortLat = (q.shortLat & ~(shortRead ? 6'h3f : 6'h00)) | shortSet; // RULE19

      // fault shutdown switches the bridges off; host must write enable again
      if (q.senseS2.thermal || (|shortSet[3:0])) begin
        d.drive[`STC_DRIVE_ENABLE] = 1'b0; // RULE5 RULE13
      end

      d.oscCnt   = (q.oscCnt == OscLast) ? 2'h0 : q.oscCnt + 2'h1;
      d.pwmPulse = 1'b0;
      if (oscTick) begin
        if (q.pwmCnt >= q.pwmLen - 10'h001) begin
          d.pwmCnt   = 10'h000;
          d.pwmPulse = 1'b1;
          d.lfsr     = {q.lfsr[4:0], q.lfsr[5] ^ q.lfsr[4]};
          // lfsr spread stays below the depth limit, so no clamp is needed
          d.pwmLen   = q.pwmDet[`STC_PWMDET_DITHER] ? PwmTicks + {4'h0, q.lfsr} : PwmTicks; // RULE16
        end else begin
          d.pwmCnt = q.pwmCnt + 10'h001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q          <= '0;
      q.drive    <= `STC_DRIVE_RESET;
      q.pwmDet   <= `STC_PWMDET_RESET;
      q.position <= `STC_POSITION_RESET;
      q.pwmLen   <= PwmTicks;
      q.lfsr     <= 6'h01;
    end else begin
      q <= d;
    end
  end

  assign bridgeOn      = q.drive[`STC_DRIVE_ENABLE]; // RULE13
  assign coilAngle     = q.position; // RULE4
  assign stepDirection = q.dirOut;
  assign pwmSync       = q.pwmPulse;
  assign faultOutNO    = 1'b0;
  assign faultOutNOe   = |q.faultLat[`STC_SR1_THERMAL:`STC_SR1_UNDERVOLT] | (|q.shortLat);
  assign cfg = '{coilCurrentLevel:   q.drive[3:0],
                 currentSurgeEnable: q.drive[5],
                 activeBrake:        q.drive[4],
                 openCoilDetectTime: q.pwmDet[7:6],
                 openCoilDetectOff:  q.pwmDet[5],
                 openCoilFloat:      q.pwmDet[4],
                 sleepEnable:        q.pwmDet[3],
                 stepModeSelect:     q.pwmDet[2:0],
                 pwmDitherEnable:    q.pwmDet[`STC_PWMDET_DITHER]};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  sequence s_good_step_up;
    stepTrig && !posWrite && !errActive && effDir;
  endsequence
  sequence s_good_step_down;
    stepTrig && !posWrite && !errActive && !effDir;
  endsequence

  sequence s_pin_rise;
    ce && q.stepSync[1] && !q.stepPrev && !errActive && !posWrite;
  endsequence
  sequence s_moved;
    q.position != $past(q.position);
  endsequence

  a_step_up_one: assert property (s_good_step_up |=> q.position == POS_W'($past(q.position) + 1'b1)) // RULE17
    else $error("position did not advance by one");
  a_step_down_one: assert property (s_good_step_down |=> q.position == POS_W'($past(q.position) - 1'b1)) // RULE3
    else $error("position did not retreat by one");
  a_lost_step_hold: assert property (stepTrig && errActive && !posWrite |=> $stable(q.position)) // RULE8
    else $error("step taken during fault condition");
  a_step_loss_set: assert property ((stepTrig || posWrite) && errActive |=> q.faultLat[`STC_SR1_STEPLOSS]) // RULE8
    else $error("step loss flag not set");
  a_step_loss_clear: assert property (faultRead && !faultSet[`STC_SR1_STEPLOSS]
                                      |=> !q.faultLat[`STC_SR1_STEPLOSS]) // RULE9
    else $error("step loss flag not cleared by read");
  a_latch_hold: assert property (ce && q.faultLat[`STC_SR1_UNDERVOLT] && !faultRead
                                 |=> q.faultLat[`STC_SR1_UNDERVOLT]) // RULE19
    else $error("latched flag dropped without read");
  a_null_ignored: assert property (frameValid && frame.addr == `STC_ADDR_NULL
                                   |=> $stable(q.readWord) && $stable(q.pwmDet)) // RULE10
    else $error("null address access had an effect");
  a_parity_odd: assert property (^faultWord[8:0] && ^shortWord[8:0]) // RULE14
    else $error("status parity not odd");
  a_advance_bit: assert property (advanceWrite && !errActive && !posWrite
                                  |=> q.position != $past(q.position)) // RULE12
    else $error("advance bit did not step");
  a_short_remap: assert property (ce && q.senseS2.shortTop[0] && q.senseS2.switchUp[0]
                                  |=> q.shortLat[`STC_SR2_XPB]) // RULE7
    else $error("top short during switching not reported as bottom");
  a_pwm_bound: assert property (q.pwmLen >= PwmTicks && q.pwmLen <= PwmTicks + 10'(`STC_JIT_MAX)) // RULE16
    else $error("pwm period outside dither range");
  a_readback_zero: assert property (frameValid && !frame.write && frame.addr == `STC_ADDR_POSITION
                                    |=> q.readWord[9:POS_W] == '0) // RULE18
    else $error("unused bits read nonzero");
  a_thermal_off: assert property (ce && q.senseS2.thermal |=> !bridgeOn) // RULE13
    else $error("bridges left on in thermal shutdown");

  a_pin_steps: assert property (s_pin_rise |=> s_moved) // RULE2
    else $error("pin edge did not move position");
  a_edge_once: assert property (stepEdge |=> !stepEdge) // RULE17
    else $error("one pin edge counted twice");
  a_dir_follow: assert property (ce |=> stepDirection == $past(effDir)) // RULE3
    else $error("direction output lags effective direction");
  a_pos_load: assert property (posWrite |=> q.position == $past(frame.data[POS_W-1:0])) // RULE1
    else $error("position write not loaded");
  // a shutdown in the same cycle beats the host's enable write
  a_bridge_write: assert property (frameValid && frame.write && frame.addr == `STC_ADDR_DRIVE && // RULE13
                                   !q.senseS2.thermal && !(|shortSet[3:0])
                                   |=> bridgeOn == $past(frame.data[`STC_DRIVE_ENABLE]))
    else $error("bridge enable write not applied");
  a_spare_zero: assert property (frameValid && !frame.write && frame.addr == `STC_ADDR_SPARE // RULE18
                                 |=> q.readWord == 10'h000)
    else $error("spare register read nonzero");
  a_drive_top: assert property (frameValid && !frame.write && frame.addr == `STC_ADDR_DRIVE // RULE18
                                |=> !q.readWord[9])
    else $error("unused drive bit read nonzero");
  a_status_ro: assert property (frameValid && frame.write && frame.addr >= `STC_ADDR_FAULT // RULE14
                                |=> $stable(q.pwmDet))
    else $error("status write changed a control register");
  a_short_hold: assert property (ce && q.shortLat[`STC_SR2_XPB] && !shortRead // RULE19
                                 |=> q.shortLat[`STC_SR2_XPB])
    else $error("latched short dropped without read");
  a_short_clear: assert property (shortRead && shortSet == 6'h00 |=> q.shortLat == 6'h00) // RULE19
    else $error("short register not cleared by read");
  a_osc_tick: assert property (oscTick |=> !oscTick) // RULE15
    else $error("oscillator tick longer than one cycle");

endmodule : stepper_translator_ctrl
`default_nettype wire

/* File: testbench/stc_host_model.sv */
// host model driving serial frames on the link clock
`default_nettype none
module stc_host_model (
  input  wire logic   serialOut,
  output logic        linkClk,
  output logic        chipSelectN,
  output logic        serialIn,
  output logic [15:0] replyWord,
  output logic        replyTick
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    linkClk = 1'h0;
    chipSelectN = 1'h1;
    serialIn = 1'h0;
    replyWord = 16'h0000;
    replyTick = 1'h0;
  end
  // one frame msb first; the clock stands still between frames
  task automatic xfer(input logic [15:0] w, input logic keep);
    logic [15:0] r;
    chipSelectN = 1'h0;
    for (int i = 15; i >= 0; i--) begin
      serialIn = w[i];
      #16;
      r[i] = serialOut;
      linkClk = 1'h1;
      #16;
      linkClk = 1'h0;
    end
    #16;
    chipSelectN = 1'h1;
    serialIn = ~w[0];  // released line must not show the last bit
    #250;  // deselect gap lets the core take the frame
    if (keep) begin
      replyWord = r;
      replyTick = ~replyTick;
    end
  endtask : xfer
endmodule : stc_host_model
`default_nettype wire

/* File: testbench/test_stepper_translator_ctrl.sv */
// self-checking bench of the stepper translator control block
`default_nettype none
`include "stc_map.svh"
module test_stepper_translator_ctrl
  import stc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = `STC_PWM_TICKS * `STC_OSC_DIV;
  logic          clk;
  logic          ce;
  logic          arst_n;
  logic          advanceStepPin;
  logic          directionPin;
  logic          serialOut;
  logic          linkClk;
  logic          chipSelectN;
  logic          serialIn;
  logic          faultOutNO;
  logic          faultOutNOe;
  logic          bridgeOn;
  logic [5:0]    coilAngle;
  logic          stepDirection;
  logic          pwmSync;
  stc_cfg_type   cfg;
  stc_sense_type sense;
  logic [15:0]   replyWord;
  logic          replyTick;
  logic [9:0]    d;
  logic [15:0]   expQ[$];
  int            bad_count = 0;
  int            n_tests = 0;
  int            seed;
  int            cycles = 0;
  int            gap = 0;
  int            period = 0;
  int            spread = 0;
  wire           faultLine = faultOutNOe ? faultOutNO : 1'h1;  // open-drain with pull-up

  stepper_translator_ctrl stepper_translator_ctrl_inst (
    .clk(clk),
    .ce(ce),
    .arst_n(arst_n),
    .linkClk(linkClk),
    .chipSelectN(chipSelectN),
    .serialIn(serialIn),
    .serialOut(serialOut),
    .advanceStepPin(advanceStepPin),
    .directionPin(directionPin),
    .sense(sense),
    .faultOutNO(faultOutNO),
    .faultOutNOe(faultOutNOe),
    .bridgeOn(bridgeOn),
    .coilAngle(coilAngle),
    .stepDirection(stepDirection),
    .pwmSync(pwmSync),
    .cfg(cfg)
  );
  stc_host_model stc_host_model_inst (
    .serialOut(serialOut),
    .linkClk(linkClk),
    .chipSelectN(chipSelectN),
    .serialIn(serialIn),
    .replyWord(replyWord),
    .replyTick(replyTick)
  );

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic end_of_test();
    $display("counts: %0d compared, %0d mismatched", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // pwm period in clk cycles, plus the run ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    gap <= pwmSync ? 1 : gap + 1;
    if (pwmSync === 1'h1) period <= gap;
    if (cycles == 40000) begin
      bad_count++;
      $display("MISMATCH at %0t: run ceiling reached", $time);
      end_of_test();
    end
  end

  always @(replyTick) begin
    if (expQ.size() != 0) check(replyWord, expQ.pop_front(), "read reply");
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #3;
  endtask : tick

  task automatic wr(input logic [4:0] a, input logic [9:0] v);
    tick(1);
    stc_host_model_inst.xfer({1'h1, a, v}, 1'h0);
  endtask : wr

  // reply comes back in the following frame, fetched with a null access
  task automatic rd(input logic [4:0] a, input logic [9:0] e);
    expQ.push_back({6'h00, e});
    tick(1);
    stc_host_model_inst.xfer({1'h0, a, 10'h000}, 1'h0);
    stc_host_model_inst.xfer(16'h0000, 1'h1);
  endtask : rd

  function automatic logic [9:0] sr(input logic [7:0] v);
    return {1'h0, ~^v, v};
  endfunction : sr

  task automatic stepPulse();
    tick(1);
    advanceStepPin = 1'h1;
    tick(4);
    advanceStepPin = 1'h0;
    tick(4);
  endtask : stepPulse

  initial begin
    seed = 61169;
    arst_n = 1'h0;
    ce = 1'h1;
    advanceStepPin = 1'h0;
    directionPin = 1'h0;
    sense = '0;
    tick(10);
    arst_n = 1'h1;
    tick(4);
    check(16'(coilAngle), 16'h0008, "reset angle");
    rd(`STC_ADDR_DRIVE, 10'h000);
    rd(`STC_ADDR_PWMDET, 10'h088);
    rd(`STC_ADDR_POSITION, 10'h008);
    rd(`STC_ADDR_SPARE, 10'h000);
    rd(5'h07, 10'h000);
    $display("test reset values done");
    d = 10'($random(seed));
    wr(`STC_ADDR_DRIVE, {d[9], 1'h0, d[7:0]});
    rd(`STC_ADDR_DRIVE, {2'h0, d[7:0]});
    check(16'(bridgeOn), 16'(d[7]), "bridge level");
    check(16'(cfg[14:9]), 16'({d[3:0], d[5:4]}), "drive fields");
    check(16'(stepDirection), 16'(d[6]), "direction");
    wr(`STC_ADDR_NULL, 10'h3ff);
    rd(`STC_ADDR_DRIVE, {2'h0, d[7:0]});
    d = 10'($random(seed));
    wr(`STC_ADDR_PWMDET, d);
    rd(`STC_ADDR_PWMDET, {1'h0, d[8:0]});
    check(16'(cfg[8:0]), 16'({d[7:0], d[8]}), "pwm fields");
    wr(`STC_ADDR_POSITION, d);
    rd(`STC_ADDR_POSITION, {4'h0, d[5:0]});
    check(16'(coilAngle), 16'(d[5:0]), "written angle");
    $display("test register access done");
    wr(`STC_ADDR_POSITION, 10'h03f);
    wr(`STC_ADDR_DRIVE, 10'h000);
    tick(1);
    directionPin = 1'h1;
    stepPulse();
    check(16'(stepDirection), 16'h0001, "pin direction");
    check(16'(coilAngle), 16'h0000, "wrap up");
    wr(`STC_ADDR_DRIVE, 10'h040);
    stepPulse();
    check(16'(stepDirection), 16'h0000, "inverted direction");
    check(16'(coilAngle), 16'h003f, "wrap down");
    wr(`STC_ADDR_DRIVE, 10'h140);
    tick(3);
    check(16'(coilAngle), 16'h003e, "advance bit");
    rd(`STC_ADDR_POSITION, 10'h03e);
    tick(1);
    ce = 1'h0;
    stepPulse();
    ce = 1'h1;
    tick(4);
    check(16'(coilAngle), 16'h003e, "frozen step");
    $display("test stepping done");
    tick(1);
    sense.undervolt = 1'h1;
    stepPulse();
    sense.undervolt = 1'h0;
    tick(4);
    check(16'(coilAngle), 16'h003e, "lost step holds");
    check(16'(faultLine), 16'h0000, "fault pin low");
    rd(`STC_ADDR_FAULT, sr(8'h82));
    rd(`STC_ADDR_FAULT, sr(8'h00));
    tick(1);
    sense.defect = 1'h1;
    tick(4);
    wr(`STC_ADDR_POSITION, 10'h011);
    rd(`STC_ADDR_FAULT, sr(8'ha0));
    sense.defect = 1'h0;
    rd(`STC_ADDR_FAULT, sr(8'h00));
    wr(`STC_ADDR_FAULT, 10'h3ff);
    rd(`STC_ADDR_FAULT, sr(8'h40));
    rd(`STC_ADDR_FAULT, sr(8'h00));
    $display("test step loss done");
    wr(`STC_ADDR_DRIVE, 10'h080);
    tick(1);
    sense.shortTop = 4'h1;
    sense.switchUp = 4'h1;
    tick(4);
    sense.shortTop = 4'h0;
    sense.switchUp = 4'h0;
    tick(4);
    check(16'(bridgeOn), 16'h0000, "short drops bridge");
    rd(`STC_ADDR_SHORT, sr(8'h08));
    rd(`STC_ADDR_SHORT, sr(8'h00));
    wr(`STC_ADDR_DRIVE, 10'h080);
    tick(2);
    check(16'(bridgeOn), 16'h0001, "bridge back on");
    check(16'(faultLine), 16'h0001, "fault pin released");
    arst_n = 1'h0;
    tick(2);
    check(16'(bridgeOn), 16'h0000, "reset drops bridge");
    check(16'(coilAngle), 16'h0008, "reset angle again");
    arst_n = 1'h1;
    tick(4);
    $display("test shorts done");
    wr(`STC_ADDR_PWMDET, 10'h088);
    repeat (3) @(posedge pwmSync);
    tick(1);
    check(16'(period), 16'(PER), "plain pwm period");
    wr(`STC_ADDR_PWMDET, 10'h188);
    repeat (2) @(posedge pwmSync);
    for (int i = 0; i < 8; i++) begin
      @(posedge pwmSync);
      tick(1);
      check(16'(period >= PER && period * 5 <= PER * 6), 16'h0001, "dither depth");
      if (period != PER) spread++;
    end
    check(16'(spread != 0), 16'h0001, "dither active");
    $display("test pwm done");
    tick(2);
    check(16'(expQ.size()), 16'h0000, "replies left");
    end_of_test();
  end
endmodule : test_stepper_translator_ctrl
`default_nettype wire
